// ---- design/aws_sequencer.sv ----
// Behaviour
// [R1] Ninety-nine separately programmed sequence points
// [R2] Block repeats 1 to 999 times or endlessly
// [R3] One target, current or voltage, per block
// [R4] Output is DC ramp plus swept sine
// [R5] Both frequencies zero gives DC only
// [R6] Point duration 0.01 ms to 36000 s
// [R7] Sine amplitudes at most half nominal
// [R8] Sine frequencies at most 10000 Hz
// [R9] Start phase 0 to 359 degrees
// [R10] DC values stay within amplitude margins
// [R11] Reject frequency sweep below 9.3 per second
// [R12] Reject too shallow amplitude slope
// [R13] Block runs first point to last point
// [R14] Amplitude stepped at every new half wave
// [R15] Periods equal duration times frequency, truncated
// [R16] Frequency sweeps across the point
// [R17] Each repetition restarts from start values
// [R18] Stop and flag done after last repetition
//
// Added by the designer: the strobed register port and the register offsets.
`include "aws_defines.svh"
`default_nettype none
module aws_sequencer #(
	parameter int VAL_W = 16,
	parameter logic [31:0] AMP_SLOPE_K = 32'd100000
) (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic CE,
	input wire logic [9:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	output logic [VAL_W-1:0] SETPOINT,
	output logic TARGET_VOLT,
	output logic BUSY,
	output logic DONE,
	output logic ERR
);
	// ==========================================================
	// Elaboration check
	if (VAL_W < 8 || VAL_W > 16) begin : g_bad_width
		$error("VAL_W must lie between 8 and 16");
	end

	localparam logic [15:0] NOM = 16'((32'd1 << VAL_W) - 32'd1);
	localparam logic [15:0] HALF = NOM >> 1;

	// ==========================================================
	// Point table and globals
	logic [31:0] mem [8:799];
	logic [6:0] first_r;
	logic [6:0] last_r;
	logic [9:0] cycles_r;
	logic volt_r;
	logic [31:0] rdata_r;
	aws_pkg::aws_state_type st_r;

	wire [6:0] bus_pg = ADDR[9:3];
	wire [2:0] bus_sl = ADDR[2:0];
	wire bus_glob = (bus_pg == 7'h00);
	wire bus_pt = (bus_pg != 7'h00) && (bus_pg <= `AWS_POINTS);
	wire idle = (st_r == aws_pkg::AWS_IDLE);
	wire wr_ctrl = WR && bus_glob && (bus_sl == `AWS_G_CTRL);
	wire start_req = wr_ctrl && WDATA[`AWS_CTRL_START] && idle;
	wire stop_req = wr_ctrl && WDATA[`AWS_CTRL_STOP];
	// Block limits checked once, at start
	wire glob_ok = (first_r >= 7'd1) && (first_r <= last_r) && (last_r <= `AWS_POINTS)
		&& (cycles_r <= `AWS_CYC_MAX); // [R13] [R2]

	// Point memory write
	always_ff @(posedge MCLK) begin
		if (CE && WR && bus_pt) begin
			mem[ADDR] <= WDATA; // [R1]
		end
	end

	// Globals; target and limits are locked while a block runs
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			first_r <= 7'h01;
			last_r <= 7'h01;
			cycles_r <= 10'h001;
			volt_r <= 1'b0;
		end else if (CE && WR && bus_glob && idle) begin
			unique case (bus_sl)
				`AWS_G_CTRL: volt_r <= WDATA[`AWS_CTRL_VOLT]; // [R3]
				`AWS_G_FIRST: first_r <= WDATA[6:0];
				`AWS_G_LAST: last_r <= WDATA[6:0];
				`AWS_G_CYCLES: cycles_r <= WDATA[9:0];
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Point parameters as loaded
	logic [31:0] par_r [8];
	logic [6:0] pt_r;
	logic [2:0] ld_r;
	logic [9:0] rep_r;
	logic done_r;
	logic err_r;
	logic busy_r; // BUSY straight from a flop, mirrors the non-idle states

	wire [15:0] a_b = par_r[`AWS_P_AMP_B][15:0];
	wire [15:0] a_f = par_r[`AWS_P_AMP_F][15:0];
	wire [15:0] f_b = par_r[`AWS_P_FRQ_B][15:0];
	wire [15:0] f_f = par_r[`AWS_P_FRQ_F][15:0];
	wire [15:0] ang = par_r[`AWS_P_ANGLE][15:0];
	wire [15:0] o_b = par_r[`AWS_P_OFS_B][15:0];
	wire [15:0] o_f = par_r[`AWS_P_OFS_F][15:0];
	wire [31:0] dur = par_r[`AWS_P_DUR];

	// Magnitudes and signs of the three sweeps
	wire o_neg = o_f < o_b;
	wire a_neg = a_f < a_b;
	wire f_neg = f_f < f_b;
	wire [15:0] o_mag = o_neg ? o_b - o_f : o_f - o_b;
	wire [15:0] a_mag = a_neg ? a_b - a_f : a_f - a_b;
	wire [15:0] f_mag = f_neg ? f_b - f_f : f_f - f_b;

	// Point validity
	wire ok_dur = (dur >= `AWS_DUR_MIN) && (dur <= `AWS_DUR_MAX); // [R6]
	wire ok_amp = (a_b <= HALF) && (a_f <= HALF); // [R7]
	wire ok_frq = (f_b <= `AWS_FREQ_MAX) && (f_f <= `AWS_FREQ_MAX); // [R8]
	wire ok_ang = ang <= `AWS_ANGLE_MAX; // [R9]
	wire ok_ofs = (o_b >= a_b) && ({1'b0, o_b} <= {1'b0, NOM} - {1'b0, a_b})
		&& (o_f >= a_f) && ({1'b0, o_f} <= {1'b0, NOM} - {1'b0, a_f}); // [R10]
	wire [39:0] sw_lhs = 40'(f_mag) * `AWS_SWEEP_NUM;
	wire [39:0] sw_rhs = 40'(dur) * `AWS_SWEEP_DEN;
	wire ok_swp = (f_mag == 16'h0) || (sw_lhs >= sw_rhs); // [R11]
	wire [47:0] sl_lhs = 48'(a_mag) * 48'(AMP_SLOPE_K);
	wire ok_slp = (a_mag == 16'h0) || (sl_lhs >= 48'(dur)); // [R12]
	wire pt_ok = ok_dur && ok_amp && ok_frq && ok_ang && ok_ofs && ok_swp && ok_slp;

	// ==========================================================
	// Serial divider: step = (|delta| << FRAC) / duration
	logic [32:0] dv_rem_r;
	logic [55:0] dv_q_r;
	logic [5:0] dv_cnt_r;
	logic [1:0] dv_sel_r;
	logic signed [41:0] o_stp_r;
	logic signed [41:0] a_stp_r;
	logic signed [41:0] f_stp_r;

	wire [32:0] dv_try = {dv_rem_r[31:0], dv_q_r[55]};
	wire dv_ge = dv_try >= {1'b0, dur};
	wire [32:0] dv_rem_nxt = dv_ge ? dv_try - {1'b0, dur} : dv_try;
	wire [55:0] dv_q_nxt = {dv_q_r[54:0], dv_ge};
	wire dv_last = (dv_cnt_r == 6'd55);
	wire dv_neg = (dv_sel_r == 2'd0) ? o_neg : (dv_sel_r == 2'd1) ? a_neg : f_neg;
	wire [41:0] dv_abs = {2'b00, dv_q_nxt[39:0]};
	wire signed [41:0] dv_step = dv_neg ? -$signed(dv_abs) : $signed(dv_abs);
	wire [15:0] dv_mag_next = (dv_sel_r == 2'd0) ? a_mag : f_mag;
	wire [15:0] dv_mag0 = o_mag;

	// ==========================================================
	// Waveform accumulators
	logic signed [41:0] o_acc_r;
	logic signed [41:0] a_acc_r;
	logic signed [41:0] f_acc_r;
	logic [15:0] a_hold_r;
	logic [31:0] ph_r;
	logic [31:0] tick_r;
	logic [11:0] pre_r;
	logic [VAL_W-1:0] set_r;

	wire tick = (pre_r == 12'(`AWS_TICK_CYC - 1));
	wire pt_end = tick && (tick_r == dur - 32'd1); // [R6] [R15]
	wire blk_end = pt_r == last_r;
	wire rep_end = (cycles_r != 10'h0) && (rep_r + 10'd1 == cycles_r); // [R2] [R18]
	wire ac_on = (f_b != 16'h0) || (f_f != 16'h0); // [R5]

	// Current frequency drives the phase step
	wire [15:0] f_now = f_acc_r[`AWS_FRAC+15:`AWS_FRAC];
	wire [31:0] ph_inc = 32'(f_now * `AWS_PH_PER_HZ); // [R16]
	wire [31:0] ph_nxt = ph_r + ph_inc;
	wire half_new = ph_nxt[31] != ph_r[31];
	wire [31:0] ph_start = 32'(ang * `AWS_PH_PER_DEG); // [R9]

	// Parabolic half-wave shape: 4x(1-x) across each half period
	wire [15:0] sx = ph_r[30:15];
	wire [31:0] sprod = sx * (16'hffff - sx);
	wire [16:0] sy = sprod[30:14];
	wire [32:0] ac_prod = a_hold_r * sy;
	wire [17:0] ac_mag = ac_on ? {1'b0, ac_prod[32:16]} : 18'h0; // [R5]
	wire signed [19:0] dc_now = 20'(o_acc_r[41:`AWS_FRAC]);
	wire signed [19:0] ac_sig = ph_r[31] ? -$signed({2'b00, ac_mag}) : $signed({2'b00, ac_mag});
	wire signed [19:0] val = dc_now + ac_sig; // [R4]
	wire [VAL_W-1:0] val_clip = (val < 0) ? '0
		: (val > $signed({4'h0, NOM})) ? NOM[VAL_W-1:0] : val[VAL_W-1:0];

	// ==========================================================
	// Sequencer
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			st_r <= aws_pkg::AWS_IDLE;
			pt_r <= 7'h01;
			ld_r <= 3'h0;
			rep_r <= 10'h0;
			done_r <= 1'b0;
			err_r <= 1'b0;
			busy_r <= 1'b0;
		end else if (CE) begin
			if (stop_req) begin
				st_r <= aws_pkg::AWS_IDLE;
				busy_r <= 1'b0;
			end else begin
				unique case (st_r)
					aws_pkg::AWS_IDLE: if (start_req) begin
						done_r <= 1'b0;
						err_r <= !glob_ok;
						pt_r <= first_r; // [R13]
						rep_r <= 10'h0;
						ld_r <= 3'h0;
						if (glob_ok) begin
							st_r <= aws_pkg::AWS_LOAD;
							busy_r <= 1'b1;
						end
					end
					aws_pkg::AWS_LOAD: begin
						ld_r <= ld_r + 3'h1;
						if (ld_r == 3'h7) st_r <= aws_pkg::AWS_CHECK;
					end
					aws_pkg::AWS_CHECK: begin
						err_r <= !pt_ok;
						busy_r <= pt_ok;
						st_r <= pt_ok ? aws_pkg::AWS_DIV : aws_pkg::AWS_IDLE;
					end
					aws_pkg::AWS_DIV: if (dv_last && dv_sel_r == 2'd2) begin
						st_r <= aws_pkg::AWS_RUN;
					end
					aws_pkg::AWS_RUN: if (pt_end) begin
						ld_r <= 3'h0;
						if (!blk_end) begin
							pt_r <= pt_r + 7'h01;
							st_r <= aws_pkg::AWS_LOAD;
						end else if (rep_end) begin
							done_r <= 1'b1; // [R18]
							busy_r <= 1'b0;
							st_r <= aws_pkg::AWS_IDLE;
						end else begin
							rep_r <= rep_r + 10'd1;
							pt_r <= first_r; // [R2]
							st_r <= aws_pkg::AWS_LOAD;
						end
					end
				endcase
			end
		end
	end

	// Parameter fetch from the table
	always_ff @(posedge MCLK) begin
		if (CE && st_r == aws_pkg::AWS_LOAD) begin
			par_r[ld_r] <= mem[{pt_r, ld_r}];
		end
	end

	// Divider runs dc, then amplitude, then frequency
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			dv_rem_r <= 33'h0;
			dv_q_r <= 56'h0;
			dv_cnt_r <= 6'h0;
			dv_sel_r <= 2'd0;
			o_stp_r <= 42'sh0;
			a_stp_r <= 42'sh0;
			f_stp_r <= 42'sh0;
		end else if (CE) begin
			if (st_r == aws_pkg::AWS_CHECK) begin
				dv_rem_r <= 33'h0;
				dv_q_r <= {16'h0, dv_mag0, 24'h0};
				dv_cnt_r <= 6'h0;
				dv_sel_r <= 2'd0;
			end else if (st_r == aws_pkg::AWS_DIV) begin
				dv_cnt_r <= dv_last ? 6'h0 : dv_cnt_r + 6'h1;
				dv_rem_r <= dv_last ? 33'h0 : dv_rem_nxt;
				dv_q_r <= dv_last ? {16'h0, dv_mag_next, 24'h0} : dv_q_nxt;
				if (dv_last) begin
					dv_sel_r <= dv_sel_r + 2'd1;
					unique case (dv_sel_r)
						2'd0: o_stp_r <= dv_step;
						2'd1: a_stp_r <= dv_step;
						default: f_stp_r <= dv_step;
					endcase
				end
			end
		end
	end

	// Tick prescaler and point timer
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			pre_r <= 12'h0;
			tick_r <= 32'h0;
		end else if (CE) begin
			if (st_r != aws_pkg::AWS_RUN) begin
				pre_r <= 12'h0;
				tick_r <= 32'h0;
			end else begin
				pre_r <= tick ? 12'h0 : pre_r + 12'h1;
				if (tick) tick_r <= tick_r + 32'h1;
			end
		end
	end

	// Ramps restart from the start values on every point run
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			o_acc_r <= 42'sh0;
			a_acc_r <= 42'sh0;
			f_acc_r <= 42'sh0;
			a_hold_r <= 16'h0;
			ph_r <= 32'h0;
		end else if (CE) begin
			if (st_r == aws_pkg::AWS_DIV) begin
				o_acc_r <= $signed({2'b00, o_b, 24'h0}); // [R17]
				a_acc_r <= $signed({2'b00, a_b, 24'h0}); // [R17]
				f_acc_r <= $signed({2'b00, f_b, 24'h0}); // [R17]
				a_hold_r <= a_b;
				ph_r <= ph_start; // [R9]
			end else if (st_r == aws_pkg::AWS_RUN && tick) begin
				o_acc_r <= o_acc_r + o_stp_r; // [R4]
				a_acc_r <= a_acc_r + a_stp_r;
				f_acc_r <= f_acc_r + f_stp_r; // [R16]
				ph_r <= ph_nxt; // [R15]
				if (half_new) a_hold_r <= a_acc_r[`AWS_FRAC+15:`AWS_FRAC]; // [R14]
			end
		end
	end

	// Set value output, zero outside a run
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			set_r <= '0;
		end else if (CE) begin
			set_r <= (st_r == aws_pkg::AWS_RUN) ? val_clip : '0; // [R4]
		end
	end

	// ==========================================================
	// Register read, one cycle after the strobe
	wire [31:0] status = {16'h0, 1'b0, pt_r, 5'h0, err_r, done_r, !idle};
	wire [31:0] glob_rd = (bus_sl == `AWS_G_CTRL) ? {29'h0, volt_r, 2'b00}
		: (bus_sl == `AWS_G_FIRST) ? {25'h0, first_r}
		: (bus_sl == `AWS_G_LAST) ? {25'h0, last_r}
		: (bus_sl == `AWS_G_CYCLES) ? {22'h0, cycles_r}
		: (bus_sl == `AWS_G_STATUS) ? status
		: (bus_sl == `AWS_G_SETPT) ? 32'(set_r) : 32'h0;
	wire [31:0] rd_val = bus_glob ? glob_rd : bus_pt ? mem[ADDR] : 32'h0;

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			rdata_r <= 32'h0;
		end else if (CE) begin
			rdata_r <= RD ? rd_val : 32'h0;
		end
	end

	assign RDATA = rdata_r;
	assign SETPOINT = set_r;
	assign TARGET_VOLT = volt_r; // [R3]
	assign BUSY = busy_r;
	assign DONE = done_r;
	assign ERR = err_r;
endmodule
`default_nettype wire

// ---- design/aws_defines.svh ----
`ifndef AWS_DEFINES_SVH
`define AWS_DEFINES_SVH
// ==========================================================
// Timing
`define AWS_MCLK_NS 5
`define AWS_TICK_NS 10000
`define AWS_TICK_CYC (`AWS_TICK_NS / `AWS_MCLK_NS)
`define AWS_TICKS_PER_S 100000
// ==========================================================
// Limits of the point table
`define AWS_POINTS 7'd99
`define AWS_CYC_MAX 10'd999
`define AWS_FREQ_MAX 16'd10000
`define AWS_ANGLE_MAX 16'd359
`define AWS_DUR_MIN 32'd1
`define AWS_DUR_MAX 32'd3600000000
// Sweep minimum: |df| * 1e6 >= 93 * ticks, ticks of 10 us
`define AWS_SWEEP_NUM 40'd1000000
`define AWS_SWEEP_DEN 40'd93
// Phase step per Hz per tick (2^32 / 1e5) and per degree (2^32 / 360)
`define AWS_PH_PER_HZ 32'd42950
`define AWS_PH_PER_DEG 32'd11930465
`define AWS_FRAC 24
// ==========================================================
// Register map: page 0 global, pages 1..99 one point each
`define AWS_G_CTRL 3'h0
`define AWS_G_FIRST 3'h1
`define AWS_G_LAST 3'h2
`define AWS_G_CYCLES 3'h3
`define AWS_G_STATUS 3'h4
`define AWS_G_SETPT 3'h5
// Point slots
`define AWS_P_AMP_B 3'h0
`define AWS_P_AMP_F 3'h1
`define AWS_P_FRQ_B 3'h2
`define AWS_P_FRQ_F 3'h3
`define AWS_P_ANGLE 3'h4
`define AWS_P_OFS_B 3'h5
`define AWS_P_OFS_F 3'h6
`define AWS_P_DUR 3'h7
// Control bits
`define AWS_CTRL_START 0
`define AWS_CTRL_STOP 1
`define AWS_CTRL_VOLT 2
`endif

// ---- design/aws_pkg.sv ----
`default_nettype none
package aws_pkg;
	// ==========================================================
	// Sequencer states
	typedef enum logic [2:0] {
		AWS_IDLE,
		AWS_LOAD,
		AWS_CHECK,
		AWS_DIV,
		AWS_RUN
	} aws_state_type;
endpackage
`default_nettype wire

// ---- verification/aws_sequencer_properties.sv ----
`default_nettype none
// ==========================================================
// Port checks of the sequencer
module aws_seq_props #(
	parameter int VAL_W = 16
) (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic CE,
	input wire logic [9:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [31:0] RDATA,
	input wire logic [VAL_W-1:0] SETPOINT,
	input wire logic TARGET_VOLT,
	input wire logic BUSY,
	input wire logic DONE,
	input wire logic ERR
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge MCLK);
	endclocking
	default disable iff (RST);
	// Start and stop writes to the control word
	wire logic start_w = WR && ADDR == 10'h000 && WDATA[0];
	wire logic stop_w = WR && ADDR == 10'h000 && WDATA[1];
	property p_rd_idle;
		$past(CE) && !$past(RD) |-> RDATA == 32'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	property p_sp_idle;
		!BUSY && !$past(BUSY) |-> SETPOINT == '0;
	endproperty
	a_sp_idle: assert property (p_sp_idle) else $error("set value while idle");
	property p_volt_hold;
		BUSY && $past(BUSY) |-> $stable(TARGET_VOLT);
	endproperty
	a_volt_hold: assert property (p_volt_hold) else $error("target moved in run");
	property p_start_cause;
		$rose(BUSY) |-> $past(start_w);
	endproperty
	a_start_cause: assert property (p_start_cause) else $error("run without start");
	property p_start_clr;
		$rose(BUSY) |-> !DONE && !ERR;
	endproperty
	a_start_clr: assert property (p_start_clr) else $error("flags kept on start");
	property p_err_idle;
		$rose(ERR) |-> ##[0:1] !BUSY;
	endproperty
	a_err_idle: assert property (p_err_idle) else $error("busy after error");
	property p_done_clean;
		$rose(DONE) |-> ##[0:1] (!BUSY && !ERR);
	endproperty
	a_done_clean: assert property (p_done_clean) else $error("done while busy");
	property p_stop_cause;
		$fell(BUSY) |-> $past(stop_w) or ##[0:1] (DONE || ERR);
	endproperty
	a_stop_cause: assert property (p_stop_cause) else $error("run ended silently");
endmodule
bind aws_sequencer aws_seq_props #(.VAL_W(VAL_W)) u_props (.MCLK(MCLK), .RST(RST), .CE(CE),
	.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SETPOINT(SETPOINT),
	.TARGET_VOLT(TARGET_VOLT), .BUSY(BUSY), .DONE(DONE), .ERR(ERR));
`default_nettype wire

// ---- verification/tb.sv ----
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic MCLK, RST, CE, WR, RD, TARGET_VOLT, BUSY, DONE, ERR;
	logic [9:0] ADDR;
	logic [31:0] WDATA, RDATA, v;
	logic [15:0] SETPOINT;
	int mismatches = 0;
	int total_checks = 0;
	// Rising DC point, amplitude set but no frequency, crest angle, two ticks
	logic [31:0] good [8] = '{32'h100, 32'h100, 32'h0, 32'h0, 32'h5a, 32'h1234, 32'h1834, 32'h2};
	// Address, write data, expected read back
	logic [73:0] rows [8] = '{{10'h008, 32'h100, 32'h100}, {10'h00b, 32'h2710, 32'h2710},
		{10'h00c, 32'h167, 32'h167}, {10'h00f, 32'hd693a400, 32'hd693a400},
		{10'h31d, 32'h4321, 32'h4321}, {10'h320, 32'h55, 32'h0},
		{10'h006, 32'h77, 32'h0}, {10'h005, 32'hff, 32'h0}};
	// Two overriding writes that must make a start fail
	logic [83:0] bad [10] = '{{10'h00b, 32'h2711, 10'h00b, 32'h2711},
		{10'h00c, 32'h168, 10'h00c, 32'h168}, {10'h008, 32'h8000, 10'h009, 32'h8000},
		{10'h009, 32'h2000, 10'h009, 32'h2000}, {10'h00b, 32'hb, 10'h00f, 32'h7a120},
		{10'h009, 32'h101, 10'h00f, 32'h30d40}, {10'h001, 32'h0, 10'h001, 32'h0},
		{10'h002, 32'h64, 10'h002, 32'h64}, {10'h001, 32'h2, 10'h001, 32'h2},
		{10'h003, 32'h3e8, 10'h003, 32'h3e8}};
	aws_sequencer DUT (.MCLK(MCLK), .RST(RST), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
		.RD(RD), .RDATA(RDATA), .SETPOINT(SETPOINT), .TARGET_VOLT(TARGET_VOLT), .BUSY(BUSY),
		.DONE(DONE), .ERR(ERR));
	// ==========================================================
	// Bus and compare tasks
	task chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			mismatches++;
			$display("BAD %0t seen %h want %h", $time, s, e);
		end
	endtask
	task wr(input logic [9:0] a, input logic [31:0] d);
		@(posedge MCLK);
		WR <= 1'b1;
		ADDR <= a;
		WDATA <= d;
		@(posedge MCLK);
		WR <= 1'b0;
	endtask
	task rd(input logic [9:0] a);
		@(posedge MCLK);
		RD <= 1'b1;
		ADDR <= a;
		@(posedge MCLK);
		RD <= 1'b0;
		#1 v = RDATA;
	endtask
	// Good point on page 1, block of one point
	task setup(input logic [31:0] cyc);
		for (int i = 0; i < 8; i++) wr({7'h01, i[2:0]}, good[i]);
		wr(10'h001, 32'h1);
		wr(10'h002, 32'h1);
		wr(10'h003, cyc);
	endtask
	// Delay first so a clearing start has landed
	task wait_end(input int n);
		#1;
		for (int i = 0; i < n && DONE !== 1'b1 && ERR !== 1'b1; i++) @(posedge MCLK);
		repeat (2) @(posedge MCLK);
		#1;
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// ==========================================================
	// Clock, watchdog and tests
	initial begin
		MCLK = 1'b0;
		forever #2.5 MCLK = ~MCLK;
	end
	initial begin
		repeat (60000) @(posedge MCLK);
		mismatches++;
		close_out;
	end
	initial begin
		RST = 1'b1;
		CE = 1'b1;
		WR = 1'b0;
		RD = 1'b0;
		ADDR = 10'h0;
		WDATA = 32'h0;
		repeat (8) @(posedge MCLK);
		RST <= 1'b0;
		for (int i = 1; i < 4; i++) begin
			rd(i[9:0]);
			chk(v, 32'h1);
		end
		chk({28'h0, BUSY, DONE, ERR, TARGET_VOLT}, 32'h0);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			wr(rows[i][73:64], rows[i][63:32]);
			rd(rows[i][73:64]);
			chk(v, rows[i][31:0]);
		end
		$display("test table done");
		for (int i = 0; i < 10; i++) begin
			setup(32'h1);
			wr(bad[i][83:74], bad[i][73:42]);
			wr(bad[i][41:32], bad[i][31:0]);
			wr(10'h000, 32'h1);
			wait_end(400);
			chk({30'h0, ERR, BUSY}, 32'h2);
		end
		$display("test refused done");
		// Two passes, voltage target, DC only
		setup(32'h2);
		wr(10'h000, 32'h5);
		repeat (300) @(posedge MCLK);
		#1 chk({14'h0, TARGET_VOLT, BUSY, SETPOINT}, {14'h0, 2'b11, 16'h1234});
		// One tick of two gone: halfway up the DC ramp
		repeat (2200) @(posedge MCLK);
		#1 chk({15'h0, BUSY, SETPOINT}, {15'h0, 1'b1, 16'h1534});
		// Two ticks gone: point over, reloading for the second pass
		repeat (1700) @(posedge MCLK);
		#1 chk({15'h0, BUSY, SETPOINT}, {15'h0, 1'b1, 16'h0});
		repeat (400) @(posedge MCLK);
		#1 chk({15'h0, BUSY, SETPOINT}, {15'h0, 1'b1, 16'h1234});
		wait_end(9000);
		chk({13'h0, BUSY, DONE, ERR, SETPOINT}, {13'h0, 3'b010, 16'h0});
		$display("test run done");
		// Endless, a refused restart, then stop
		setup(32'h0);
		wr(10'h000, 32'h1);
		repeat (9000) @(posedge MCLK);
		wr(10'h000, 32'h5);
		#1 chk({28'h0, TARGET_VOLT, BUSY, DONE, ERR}, 32'h4);
		rd(10'h004);
		chk(v, 32'h101);
		wr(10'h000, 32'h2);
		repeat (2) @(posedge MCLK);
		#1 chk({30'h0, BUSY, DONE}, 32'h0);
		$display("test endless done");
		// Reset in mid-run restores the globals
		wr(10'h003, 32'h7);
		wr(10'h000, 32'h1);
		repeat (50) @(posedge MCLK);
		RST <= 1'b1;
		repeat (2) @(posedge MCLK);
		RST <= 1'b0;
		rd(10'h003);
		chk(v, 32'h1);
		chk({15'h0, BUSY, SETPOINT}, 32'h0);
		// Clock enable low: a write to the first-point register is not taken
		@(posedge MCLK);
		CE <= 1'b0;
		wr(10'h001, 32'h5);
		CE <= 1'b1;
		rd(10'h001);
		chk(v, 32'h1);
		$display("test mid reset done");
		close_out;
	end
endmodule
`default_nettype wire
